/* File: complementary_waveform_modes_bench.sv */
// self-checking bench for the complementary waveform mode block
`timescale 1ns/100ps
`default_nettype none
module complementary_waveform_modes_bench
  import cwm_pkg::*;
();
  logic        clk, rst_n, psel, penable, pwrite, data_in, sd_n;
  logic        pready, pslverr, slverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  cur;
  logic [3:0]  pp_exp [4] = '{4'hD, 4'h2, 4'hD, 4'hD};
  wire  [3:0]  outs, oes, pad;
  int          errors, check_count, cyc, n;

  cwm_core dut (
    .CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .DATA_IN(data_in),
    .SHUTDOWN_IN_N(sd_n),
    .WAVE_OUT_A(outs[0]), .WAVE_OUT_B(outs[1]), .WAVE_OUT_C(outs[2]),
    .WAVE_OUT_D(outs[3]), .WAVE_OE_A(oes[0]), .WAVE_OE_B(oes[1]),
    .WAVE_OE_C(oes[2]), .WAVE_OE_D(oes[3])
  );
  cwm_driver_model u_drv (.out(outs), .oe(oes), .pad(pad));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd      = prdata;
    slverr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // mode only moves while disabled, then the enable follows alone
  task automatic setm(input logic [2:0] m);
    apb(1'b1, CWM_ADDR_CTRL, 32'(cur));
    apb(1'b1, CWM_ADDR_CTRL, 32'(m));
    apb(1'b1, CWM_ADDR_CTRL, 32'h80 | 32'(m));
    cur = m;
  endtask

  task automatic wt(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic dat(input logic v);
    @(posedge clk);
    data_in <= v;
  endtask

  // edges counted until output i turns high
  task automatic dly(input int i);
    n = 0;
    while (outs[i] !== 1'b1 && n < 99) begin
      wt(1);
      n++;
    end
  endtask

  initial begin
    {rst_n, psel, penable, pwrite, data_in} = '0;
    paddr  = '0;
    pwdata = '0;
    sd_n   = 1'b1;
    cur    = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wt(2);
    chk("reset out", 4'hF, outs);
    chk("reset oe", 4'hF, oes);
    apb(1'b0, CWM_ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h0, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 1'b1, slverr);
    apb(1'b1, CWM_ADDR_POL, 32'h5);
    wt(3);
    chk("disabled", 4'hA, outs);
    for (int m = 6; m < 8; m++) begin
      setm(3'(m));
      wt(3);
      chk("reserved", 4'hA, outs);
    end
    apb(1'b1, CWM_ADDR_POL, 32'hF);
    apb(1'b1, CWM_ADDR_DEAD, 32'h0203);
    setm(CWM_MODE_HALF);
    dat(1'b1);
    dly(0);
    chk("rise delay", 1'b1, n >= 3 && n <= 5);
    chk("half high", 4'h5, outs);
    dat(1'b0);
    dly(1);
    chk("fall delay", 1'b1, n >= 2 && n <= 4);
    chk("half low", 4'hA, outs);
    apb(1'b1, CWM_ADDR_POL, 32'h7);
    setm(CWM_MODE_PUSH);
    for (int i = 0; i < 4; i++) begin
      if (i == 3) begin
        @(posedge clk);
        sd_n <= 1'b0;
        wt(3);
        chk("pp shutdown", 4'h0, outs);
        @(posedge clk);
        sd_n <= 1'b1;
      end
      dat(1'b1);
      wt(3);
      chk("push pull", pp_exp[i], outs);
      dat(1'b0);
      wt(3);
    end
    apb(1'b1, CWM_ADDR_POL, 32'hF);
    apb(1'b1, CWM_ADDR_DEAD, 32'h0204);
    setm(CWM_MODE_FWD);
    dat(1'b1);
    wt(3);
    chk("forward", 4'h9, outs);
    apb(1'b1, CWM_ADDR_CTRL, 32'h80 | 32'(CWM_MODE_REV));
    cur = CWM_MODE_REV;
    wt(3);
    chk("held to edge", 4'h9, outs);
    dat(1'b0);
    wt(3);
    chk("forward low", 4'h1, outs);
    dat(1'b1);
    wt(2);
    chk("swap", 4'h4, outs);
    dly(1);
    chk("reverse delay", 1'b1, n >= 2 && n <= 4);
    chk("reverse", 4'h6, outs);
    apb(1'b1, CWM_ADDR_POL, 32'h0);
    apb(1'b1, CWM_ADDR_SHDN, 32'h90);
    apb(1'b1, CWM_ADDR_STEER, 32'h0403);
    setm(CWM_MODE_ASTEER);
    wt(3);
    chk("steer", 4'h4, outs);
    @(posedge clk);
    sd_n <= 1'b0;
    wt(3);
    chk("shutdown oe", 4'hD, oes);
    chk("shutdown pad", 4'h5, pad);
    @(posedge clk);
    sd_n <= 1'b1;
    apb(1'b1, CWM_ADDR_STEER, 32'h0502);
    wt(2);
    chk("async steer", 1'b1, outs[0]);
    setm(CWM_MODE_SSTEER);
    apb(1'b1, CWM_ADDR_STEER, 32'h0503);
    wt(3);
    chk("sync holds", 1'b1, outs[0]);
    dat(1'b0);
    dat(1'b1);
    wt(3);
    chk("sync applied", 1'b0, outs[0]);
    // software shutdown drives A to its override level, ignoring polarity
    apb(1'b1, CWM_ADDR_SHDN, 32'h91);
    wt(3);
    chk("sw shutdown", 1'b1, outs[0]);
    apb(1'b0, CWM_ADDR_SHDN, 32'h0);
    chk("shdn read", 32'h93, rd);
    apb(1'b0, CWM_ADDR_STAT, 32'h0);
    chk("status", 32'hE5, rd);
    summarize();
  end
endmodule
`default_nettype wire

/* File: cwm_core.sv */
// complementary waveform mode logic with apb register slave
`timescale 1ns/100ps
`default_nettype none
// How it works
// - a three-bit mode field picks one of six output behaviours
// - one data input feeds four outputs; shutdown acts in every mode
// - half-bridge: A true, B inverted, with dead time, no steering
// - half-bridge: C and D mirror A and B with own polarity
// - push-pull: successive input pulses alternate between A and B
// - push-pull sequencer resets on disable or shutdown; first pulse on A
// - push-pull: C copies A and D copies B, each with own polarity
// - forward bridge: A active, B and C inactive, D modulated
// - reverse bridge: C active, A and D inactive, B modulated
// - lowest mode bit may toggle while enabled to change direction
// - direction change takes effect at next rising data edge
// - forward to reverse swaps A and C, idles D, modulates B after dead time
// - bridge dead time only at direction change, only on modulated output
// - steering: steer bit 0 holds fixed level, 1 follows the input
// - steering: polarity applies only to steered outputs
// - steering modes use no dead time
// - steering: shutdown overrides only steered outputs
// - synchronous steering: steer bits are synchronised, fixed levels applied directly
// - synchronous steering updates at next rising data edge
// - asynchronous steering updates right after the register write
// - polarity bit set means active high; overrides ignore polarity
// - two 6-bit dead time counters count module clock periods
// - reverse dead time delays B, forward dead time delays D
// - rising dead time delays A turn-on, falling delays B turn-on
module cwm_core
  import cwm_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        DATA_IN,
  input  wire logic        SHUTDOWN_IN_N,
  output logic             WAVE_OUT_A,
  output logic             WAVE_OUT_B,
  output logic             WAVE_OUT_C,
  output logic             WAVE_OUT_D,
  output logic             WAVE_OE_A,
  output logic             WAVE_OE_B,
  output logic             WAVE_OE_C,
  output logic             WAVE_OE_D
);

  // software registers
  logic [2:0]          mode_reg;
  logic                en_reg;
  logic [3:0]          pol_reg;
  logic [3:0]          steer_reg;
  logic [3:0]          fixed_reg;
  logic [CWM_DB_W-1:0] db_rise_reg;
  logic [CWM_DB_W-1:0] db_fall_reg;
  logic                sw_shdn_reg;
  logic [1:0]          lvl_ac_reg;
  logic [1:0]          lvl_bd_reg;

  // block state
  logic                data_prev_reg;
  logic                shdn_prev_reg;
  logic [3:0]          steer_act_reg;
  logic                dir_reg;
  logic                pp_cur_b_reg;
  logic                pp_next_b_reg;
  logic [3:0]          out_reg;
  logic [3:0]          oe_reg;
  logic [3:0]          out_next;
  logic [3:0]          oe_next;

  // bus
  logic                wr_fire;
  logic                setup;
  logic [31:0]         rd_next;
  logic                err_next;

  // derived
  logic                data_rise;
  logic                data_fall;
  logic                shdn_active;
  logic                shdn_event;
  logic                is_steer;
  logic                is_bridge;
  logic                dir_switch;
  logic                dir_eff;
  logic [3:0]          steer_eff;
  logic                pp_cur_eff;
  logic                rise_start;
  logic                fall_start;
  logic                rise_done;
  logic                fall_done;
  logic [3:0]          act;
  logic [3:0]          fixed_use;
  logic [3:0]          shdn_mask;

  // pin level for an active or inactive drive under the given polarity
  function automatic logic pol_drive(input logic pol, input logic active);
    pol_drive = pol ? active : ~active;
  endfunction

  // override level to pin value; high-z releases the enable
  function automatic logic [1:0] lvl_pin(input logic [1:0] lvl);
    if (lvl == CWM_LVL_HIGH) begin
      lvl_pin = 2'b11;
    end else if (lvl == CWM_LVL_HIZ) begin
      lvl_pin = 2'b00;
    end else begin
      lvl_pin = 2'b10;
    end
  endfunction

  assign setup   = PSEL & ~PENABLE;
  assign wr_fire = PSEL & PENABLE & PREADY & PWRITE;

  assign data_rise   = DATA_IN & ~data_prev_reg;
  assign data_fall   = ~DATA_IN & data_prev_reg;
  assign shdn_active = sw_shdn_reg | ~SHUTDOWN_IN_N;
  assign shdn_event  = shdn_active & ~shdn_prev_reg;

  assign is_steer  = (mode_reg == CWM_MODE_ASTEER) |
                     (mode_reg == CWM_MODE_SSTEER);
  assign is_bridge = (mode_reg == CWM_MODE_FWD) | (mode_reg == CWM_MODE_REV);

  // direction is only sampled on a rising data edge
  assign dir_switch = en_reg & is_bridge & data_rise &
                      (mode_reg[0] != dir_reg);
  assign dir_eff    = dir_switch ? mode_reg[0] : dir_reg;

  // synchronous steering waits for the rising edge; asynchronous does not
  assign steer_eff = ((mode_reg == CWM_MODE_SSTEER) && !data_rise) ?
                     steer_act_reg : steer_reg;

  assign pp_cur_eff = data_rise ? pp_next_b_reg : pp_cur_b_reg;

  // dead time starts: half-bridge edges, or bridge direction switches
  always_comb begin
    rise_start = 1'b0;
    fall_start = 1'b0;
    if (mode_reg == CWM_MODE_HALF) begin
      rise_start = data_rise;
      fall_start = data_fall;
    end else if (is_bridge) begin
      rise_start = dir_switch & mode_reg[0];
      fall_start = dir_switch & ~mode_reg[0];
    end
  end

  cwm_deadband u_db_rise (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .clear (~en_reg),
    .start (rise_start),
    .limit (db_rise_reg),
    .done  (rise_done)
  );

  cwm_deadband u_db_fall (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .clear (~en_reg),
    .start (fall_start),
    .limit (db_fall_reg),
    .done  (fall_done)
  );

  // active-level of each output before polarity, per mode
  always_comb begin
    act       = 4'h0;
    fixed_use = 4'h0;
    shdn_mask = 4'hF;
    case (mode_reg)
      CWM_MODE_ASTEER, CWM_MODE_SSTEER: begin
        for (int i = 0; i < 4; i++) begin
          act[i]       = steer_eff[i] & DATA_IN;
          fixed_use[i] = ~steer_eff[i];
        end
        shdn_mask = steer_eff;
      end
      CWM_MODE_FWD, CWM_MODE_REV: begin
        act[0] = ~dir_eff;
        act[2] = dir_eff;
        act[1] = dir_eff & DATA_IN & rise_done;
        act[3] = ~dir_eff & DATA_IN & fall_done;
      end
      CWM_MODE_HALF: begin
        act[0] = DATA_IN & rise_done;
        act[1] = ~DATA_IN & fall_done;
        act[2] = act[0];
        act[3] = act[1];
      end
      CWM_MODE_PUSH: begin
        act[0] = DATA_IN & ~pp_cur_eff;
        act[1] = DATA_IN & pp_cur_eff;
        act[2] = act[0];
        act[3] = act[1];
      end
      default: begin
        act = 4'h0;
      end
    endcase
  end

  // pin levels: disable, then shutdown override, then fixed, then polarity
  always_comb begin
    logic [1:0] pin;
    pin      = 2'b00;
    out_next = 4'h0;
    oe_next  = 4'hF;
    for (int i = 0; i < 4; i++) begin
      pin = lvl_pin((i == 0 || i == 2) ? lvl_ac_reg : lvl_bd_reg);
      if (!en_reg) begin
        out_next[i] = pol_drive(pol_reg[i], 1'b0);
      end else if (shdn_active && shdn_mask[i]) begin
        out_next[i] = pin[0];
        oe_next[i]  = pin[1];
      end else if (fixed_use[i]) begin
        out_next[i] = fixed_reg[i];
      end else begin
        out_next[i] = pol_drive(pol_reg[i], act[i]);
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      out_reg <= 4'h0;
      oe_reg  <= 4'h0;
    end else begin
      out_reg <= out_next;
      oe_reg  <= oe_next;
    end
  end

  assign WAVE_OUT_A = out_reg[0];
  assign WAVE_OUT_B = out_reg[1];
  assign WAVE_OUT_C = out_reg[2];
  assign WAVE_OUT_D = out_reg[3];
  assign WAVE_OE_A  = oe_reg[0];
  assign WAVE_OE_B  = oe_reg[1];
  assign WAVE_OE_C  = oe_reg[2];
  assign WAVE_OE_D  = oe_reg[3];

  // edge history of the data and shutdown inputs
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      data_prev_reg <= 1'b0;
      shdn_prev_reg <= 1'b0;
    end else begin
      data_prev_reg <= DATA_IN;
      shdn_prev_reg <= shdn_active;
    end
  end

  // applied steer bits; fixed levels bypass this stage
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      steer_act_reg <= CWM_RST_STEER;
    end else begin
      steer_act_reg <= steer_eff;
    end
  end

  // bridge direction follows the mode bit when not running a bridge
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      dir_reg <= 1'b0;
    end else if (!en_reg || !is_bridge) begin
      dir_reg <= mode_reg[0];
    end else if (dir_switch) begin
      dir_reg <= mode_reg[0];
    end
  end

  // push-pull sequencer; a shutdown event restarts it on output A
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pp_cur_b_reg  <= 1'b0;
      pp_next_b_reg <= 1'b0;
    end else if (!en_reg || shdn_event) begin
      pp_cur_b_reg  <= 1'b0;
      pp_next_b_reg <= 1'b0;
    end else if (data_rise) begin
      pp_cur_b_reg  <= pp_next_b_reg;
      pp_next_b_reg <= ~pp_next_b_reg;
    end
  end

  // control and polarity registers
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_reg <= CWM_RST_MODE;
      en_reg   <= 1'b0;
      pol_reg  <= CWM_RST_POL;
    end else if (wr_fire && PADDR == CWM_ADDR_CTRL) begin
      mode_reg <= PWDATA[CWM_CTRL_MODE_LSB +: 3];
      en_reg   <= PWDATA[CWM_CTRL_EN_BIT];
    end else if (wr_fire && PADDR == CWM_ADDR_POL) begin
      pol_reg  <= PWDATA[3:0];
    end
  end

  // steering and dead time registers
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      steer_reg   <= CWM_RST_STEER;
      fixed_reg   <= CWM_RST_FIXED;
      db_rise_reg <= CWM_RST_DB;
      db_fall_reg <= CWM_RST_DB;
    end else if (wr_fire && PADDR == CWM_ADDR_STEER) begin
      steer_reg   <= PWDATA[CWM_STEER_LSB +: 4];
      fixed_reg   <= PWDATA[CWM_FIXED_LSB +: 4];
    end else if (wr_fire && PADDR == CWM_ADDR_DEAD) begin
      db_rise_reg <= PWDATA[CWM_DB_RISE_LSB +: CWM_DB_W];
      db_fall_reg <= PWDATA[CWM_DB_FALL_LSB +: CWM_DB_W];
    end
  end

  // shutdown register; the software bit is only ever set by software
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sw_shdn_reg <= 1'b0;
      lvl_ac_reg  <= CWM_RST_LVL;
      lvl_bd_reg  <= CWM_RST_LVL;
    end else if (wr_fire && PADDR == CWM_ADDR_SHDN) begin
      sw_shdn_reg <= PWDATA[CWM_SHDN_SW_BIT];
      lvl_ac_reg  <= PWDATA[CWM_SHDN_AC_LSB +: 2];
      lvl_bd_reg  <= PWDATA[CWM_SHDN_BD_LSB +: 2];
    end
  end

  // read mux, evaluated in the setup cycle
  always_comb begin
    rd_next  = 32'h0000_0000;
    err_next = 1'b0;
    if (PADDR == CWM_ADDR_CTRL) begin
      rd_next[CWM_CTRL_MODE_LSB +: 3] = mode_reg;
      rd_next[CWM_CTRL_EN_BIT]        = en_reg;
    end else if (PADDR == CWM_ADDR_POL) begin
      rd_next[3:0] = pol_reg;
    end else if (PADDR == CWM_ADDR_STEER) begin
      rd_next[CWM_STEER_LSB +: 4] = steer_reg;
      rd_next[CWM_FIXED_LSB +: 4] = fixed_reg;
    end else if (PADDR == CWM_ADDR_DEAD) begin
      rd_next[CWM_DB_RISE_LSB +: CWM_DB_W] = db_rise_reg;
      rd_next[CWM_DB_FALL_LSB +: CWM_DB_W] = db_fall_reg;
    end else if (PADDR == CWM_ADDR_SHDN) begin
      rd_next[CWM_SHDN_SW_BIT]       = sw_shdn_reg;
      rd_next[CWM_SHDN_ACT_BIT]      = shdn_active;
      rd_next[CWM_SHDN_AC_LSB +: 2]  = lvl_ac_reg;
      rd_next[CWM_SHDN_BD_LSB +: 2]  = lvl_bd_reg;
    end else if (PADDR == CWM_ADDR_STAT) begin
      rd_next[CWM_STAT_OUT_LSB +: 4] = out_reg;
      rd_next[CWM_STAT_PP_BIT]       = pp_next_b_reg;
      rd_next[CWM_STAT_DIR_BIT]      = dir_reg;
      rd_next[CWM_STAT_RISE_BIT]     = rise_done;
      rd_next[CWM_STAT_FALL_BIT]     = fall_done;
    end else begin
      err_next = 1'b1;
    end
  end

  // no wait state; the bus answer is registered at the end of the setup cycle
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (setup) begin
      PREADY  <= 1'b1;
      PRDATA  <= PWRITE ? 32'h0000_0000 : rd_next;
      PSLVERR <= err_next;
    end else begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: cwm_core_assertions.sv */
// port checks for the complementary waveform mode block
`timescale 1ns/100ps
`default_nettype none
module cwm_core_chk
  import cwm_pkg::*;
(
  input wire logic        CORE_CLK,
  input wire logic        RST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic        DATA_IN,
  input wire logic        SHUTDOWN_IN_N,
  input wire logic        WAVE_OUT_A,
  input wire logic        WAVE_OUT_B,
  input wire logic        WAVE_OUT_C,
  input wire logic        WAVE_OUT_D,
  input wire logic        WAVE_OE_A
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  logic [7:0]  ctl_reg, shd_reg;
  logic [11:0] str_reg;
  logic [3:0]  pol_reg, act;
  logic [1:0]  q_reg, sh_reg, dh_reg;
  logic [2:0]  md;
  logic        wr, en, calm, ok, sd, idle, brg, hpp, ast;
  assign wr   = PSEL & PENABLE & PREADY & PWRITE;
  assign en   = ctl_reg[CWM_CTRL_EN_BIT];
  assign md   = ctl_reg[2:0];
  assign act  = {WAVE_OUT_D, WAVE_OUT_C, WAVE_OUT_B, WAVE_OUT_A} ~^ pol_reg;
  // outputs are judged only once three edges passed since the last write
  assign calm = q_reg == 2'h3;
  assign ok   = calm && !shd_reg[0] && (&{sh_reg, SHUTDOWN_IN_N});
  assign sd   = calm && en && (shd_reg[0] || !(|{sh_reg, SHUTDOWN_IN_N}));
  assign idle = ok && (!en || md[2:1] == 2'h3);
  assign brg  = ok && en && md[2:1] == 2'h1;
  assign hpp  = ok && en && md[2:1] == 2'h2;
  assign ast  = en && md == CWM_MODE_ASTEER;
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctl_reg <= '0;
      pol_reg <= '0;
      str_reg <= '0;
      shd_reg <= '0;
    end else if (wr) begin
      case (PADDR)
        CWM_ADDR_CTRL:  ctl_reg <= PWDATA[7:0];
        CWM_ADDR_POL:   pol_reg <= PWDATA[3:0];
        CWM_ADDR_STEER: str_reg <= PWDATA[11:0];
        CWM_ADDR_SHDN:  shd_reg <= PWDATA[7:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      q_reg  <= '0;
      sh_reg <= '0;
      dh_reg <= '0;
    end else begin
      q_reg  <= wr ? 2'h0 : q_reg + {1'b0, q_reg != 2'h3};
      sh_reg <= {sh_reg[0], SHUTDOWN_IN_N};
      dh_reg <= {dh_reg[0], DATA_IN};
    end
  end
  property p_idle; idle |-> WAVE_OE_A && act == 4'h0; endproperty
  a_idle: assert property (p_idle)
    else $error("idle outputs not inactive");
  property p_ac; brg |-> act[0] != act[2]; endproperty
  a_ac: assert property (p_ac)
    else $error("bridge a and c not opposite");
  property p_bd; brg |-> !(act[0] && act[1]) && !(act[2] && act[3]);
  endproperty
  a_bd: assert property (p_bd)
    else $error("bridge leg overlap");
  property p_hb; hpp |-> !(act[0] && act[1]); endproperty
  a_hb: assert property (p_hb)
    else $error("a and b active together");
  property p_mir; hpp |-> act[3:2] == act[1:0]; endproperty
  a_mir: assert property (p_mir)
    else $error("c or d not mirroring");
  property p_fix; calm && ast && !str_reg[0] |-> WAVE_OUT_A == str_reg[8];
  endproperty
  a_fix: assert property (p_fix)
    else $error("fixed level wrong");
  property p_fol;
    ok && ast && str_reg[0] && dh_reg[0] == dh_reg[1] |-> act[0] == dh_reg[0];
  endproperty
  a_fol: assert property (p_fol)
    else $error("steered output not following");
  property p_sdz;
    sd && md[2:1] == 2'h2 |-> WAVE_OE_A == (shd_reg[5:4] != CWM_LVL_HIZ);
  endproperty
  a_sdz: assert property (p_sdz)
    else $error("shutdown drive enable wrong");
  c_hb: cover property (hpp && !md[0] && act[0]);
  c_rev: cover property (brg && act[1]);
  c_sd: cover property (sd && ast && WAVE_OE_A);
endmodule
bind cwm_core cwm_core_chk u_chk (
  .CORE_CLK      (CORE_CLK),
  .RST_N         (RST_N),
  .PSEL          (PSEL),
  .PENABLE       (PENABLE),
  .PWRITE        (PWRITE),
  .PADDR         (PADDR),
  .PWDATA        (PWDATA),
  .PREADY        (PREADY),
  .DATA_IN       (DATA_IN),
  .SHUTDOWN_IN_N (SHUTDOWN_IN_N),
  .WAVE_OUT_A    (WAVE_OUT_A),
  .WAVE_OUT_B    (WAVE_OUT_B),
  .WAVE_OUT_C    (WAVE_OUT_C),
  .WAVE_OUT_D    (WAVE_OUT_D),
  .WAVE_OE_A     (WAVE_OE_A)
);
`default_nettype wire

/* File: cwm_deadband.sv */
// dead time counter: counts clock periods from a start pulse up to a limit
`timescale 1ns/100ps
`default_nettype none
module cwm_deadband
  import cwm_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                clear,
  input  wire logic                start,
  input  wire logic [CWM_DB_W-1:0] limit,
  output logic                     done
);

  logic [CWM_DB_W-1:0] cnt_reg;
  logic                run_reg;
  logic [CWM_DB_W-1:0] cnt_inc;

  assign cnt_inc = cnt_reg + 6'h01;
  // a zero limit means no dead time, so done stays high through the start
  assign done = ~run_reg & ~(start & (limit != 6'h00));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 6'h00;
      run_reg <= 1'b0;
    end else if (clear) begin
      cnt_reg <= 6'h00;
      run_reg <= 1'b0;
    end else if (start) begin
      cnt_reg <= 6'h00;
      run_reg <= (limit != 6'h00);
    end else if (run_reg) begin
      cnt_reg <= cnt_inc;
      if (cnt_inc == limit) begin
        run_reg <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

/* File: cwm_driver_model.sv */
// switch driver model seen at the four waveform pads
`timescale 1ns/100ps
`default_nettype none
module cwm_driver_model (
  input  wire logic [3:0] out,
  input  wire logic [3:0] oe,
  output logic      [3:0] pad
);
  // board pull-downs take an undriven pad low, never its last level
  assign pad = out & oe;
endmodule
`default_nettype wire

/* File: cwm_pkg.sv */
// constants shared by the complementary waveform mode logic
package cwm_pkg;

  // register byte offsets
  localparam logic [7:0] CWM_ADDR_CTRL  = 8'h00;
  localparam logic [7:0] CWM_ADDR_POL   = 8'h04;
  localparam logic [7:0] CWM_ADDR_STEER = 8'h08;
  localparam logic [7:0] CWM_ADDR_DEAD  = 8'h0C;
  localparam logic [7:0] CWM_ADDR_SHDN  = 8'h10;
  localparam logic [7:0] CWM_ADDR_STAT  = 8'h14;

  // control register fields
  localparam int CWM_CTRL_MODE_LSB = 0;
  localparam int CWM_CTRL_EN_BIT   = 7;

  // steering register fields
  localparam int CWM_STEER_LSB = 0;
  localparam int CWM_FIXED_LSB = 8;

  // dead time register fields
  localparam int CWM_DB_W        = 6;
  localparam int CWM_DB_RISE_LSB = 0;
  localparam int CWM_DB_FALL_LSB = 8;

  // shutdown register fields
  localparam int CWM_SHDN_SW_BIT  = 0;
  localparam int CWM_SHDN_ACT_BIT = 1;
  localparam int CWM_SHDN_AC_LSB  = 4;
  localparam int CWM_SHDN_BD_LSB  = 6;

  // status register fields
  localparam int CWM_STAT_OUT_LSB  = 0;
  localparam int CWM_STAT_PP_BIT   = 4;
  localparam int CWM_STAT_DIR_BIT  = 5;
  localparam int CWM_STAT_RISE_BIT = 6;
  localparam int CWM_STAT_FALL_BIT = 7;

  // reset values
  localparam logic [2:0] CWM_RST_MODE  = 3'h0;
  localparam logic [3:0] CWM_RST_POL   = 4'h0;
  localparam logic [3:0] CWM_RST_STEER = 4'h0;
  localparam logic [3:0] CWM_RST_FIXED = 4'h0;
  localparam logic [5:0] CWM_RST_DB    = 6'h00;
  localparam logic [1:0] CWM_RST_LVL   = 2'h0;

  // mode field encodings
  localparam logic [2:0] CWM_MODE_ASTEER = 3'h0;
  localparam logic [2:0] CWM_MODE_SSTEER = 3'h1;
  localparam logic [2:0] CWM_MODE_FWD    = 3'h2;
  localparam logic [2:0] CWM_MODE_REV    = 3'h3;
  localparam logic [2:0] CWM_MODE_HALF   = 3'h4;
  localparam logic [2:0] CWM_MODE_PUSH   = 3'h5;

  // shutdown override level encodings
  localparam logic [1:0] CWM_LVL_LOW0 = 2'h0;
  localparam logic [1:0] CWM_LVL_HIGH = 2'h1;
  localparam logic [1:0] CWM_LVL_HIZ  = 2'h2;

endpackage
